// *** verilog/csl_top.sv ***
// Behaviour
// - Three signature bytes at fixed addresses are readable by the programmer.
// - Verify readout works only while lock bits two and three are both clear.
// - Lock bit one blocks table reads from external code into internal memory.
// - Lock bit one latches the external-access select pin at reset.
// - Lock bit one refuses all further programming of internal program memory.
// - Lock bits one and two add a complete verify readout disable.
// - All three lock bits also forbid executing code from external memory.
// - Without lock bits no protection, yet verify data is scrambled by key.
`timescale 1ns/10ps

module csl_top #(
  // Signature values; arbitrary neutral identification codes.
  parameter logic [7:0] SIG_MAKER = 8'hA5,
  parameter logic [7:0] SIG_PART  = 8'h5A,
  parameter logic [7:0] SIG_EXTRA = 8'h3C
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Register port.
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // External-access select pin.
  input  wire logic        external_access_select_i,
  output logic             ea_effective_o,
  // CPU fetch path.
  input  wire logic        fetch_req_i,
  input  wire logic        fetch_from_ext_i,
  input  wire logic        code_table_read_i,
  input  wire logic [15:0] fetch_addr_i,
  input  wire logic [7:0]  int_rdata_i,
  input  wire logic [7:0]  ext_rdata_i,
  output logic      [7:0]  fetch_data_o,
  output logic             fetch_valid_o,
  output logic             fetch_denied_o,
  // Programmer port.
  input  wire logic        prog_rd_i,
  input  wire logic        prog_wr_i,
  input  wire logic [15:0] prog_addr_i,
  input  wire logic [7:0]  prog_wdata_i,
  input  wire logic [7:0]  prog_mem_rdata_i,
  output logic      [7:0]  prog_rdata_o,
  output logic             prog_rvalid_o,
  output logic             prog_denied_o,
  output logic             prog_mem_we_o,
  output logic      [15:0] prog_mem_addr_o,
  output logic      [7:0]  prog_mem_wdata_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  csl_pkg::csl_level_type level;
  logic        table_block;
  logic        ea_hold;
  logic        prog_lock;
  logic        verify_off;
  logic        ext_exec_off;

  logic [2:0]  lock_q;
  logic [2:0]  lock_d;
  logic [7:0]  key_q;
  logic [7:0]  key_d;
  logic        cap_done_q;
  logic        ea_cap_q;
  logic        ea_cap_d;
  logic        ea_q;
  logic        ea_d;
  logic [6:0]  sticky_q;
  logic [6:0]  sticky_d;
  logic [6:0]  sticky_set;
  logic [7:0]  status_val;
  logic [7:0]  reg_rd_val;

  logic        wr_lock;
  logic        wr_key;
  logic        wr_status;
  logic        hit_lock;
  logic        hit_key;
  logic        hit_status;

  logic        tgt_int;
  logic        tbl_deny;
  logic        exec_deny;
  logic        fetch_deny;
  logic [7:0]  fetch_byte;

  logic        sig_hit;
  logic [7:0]  sig_byte;
  logic        key_on;
  logic [7:0]  vfy_byte;
  logic        vfy_deny;
  logic [7:0]  prog_byte;
  logic        pwr_ok;
  logic        pwr_refused;

  ////////////////////////////////////////////////////////////////////////////
  // Lock level decoder.

  csl_lock_decode u_decode (
    .lock_bits_i    (lock_q),
    .level_o        (level),
    .table_block_o  (table_block),
    .ea_hold_o      (ea_hold),
    .prog_lock_o    (prog_lock),
    .verify_off_o   (verify_off),
    .ext_exec_off_o (ext_exec_off)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode.

  // Address hits, decoded as a priority chain of offsets.
  assign hit_lock   = (reg_addr_i == csl_pkg::REG_LOCK);
  assign hit_key    = !hit_lock && (reg_addr_i == csl_pkg::REG_KEY);
  assign hit_status = !hit_lock && !hit_key &&
                      (reg_addr_i == csl_pkg::REG_STATUS);

  assign wr_lock    = reg_wr_i && hit_lock;
  assign wr_key     = reg_wr_i && hit_key;
  assign wr_status  = reg_wr_i && hit_status;

  // Lock bits are one-time: a write can only add programmed bits.
  assign lock_d = wr_lock ? (lock_q | reg_wdata_i[2:0]) : lock_q;

  // The key is part of program memory, so it freezes with programming.
  assign key_d  = (wr_key && !prog_lock) ? reg_wdata_i : key_q;

  // Status byte: level, effective select and the sticky event flags.
  assign status_val = {1'b0,
                       sticky_q[csl_pkg::ST_VFY_DENY:csl_pkg::ST_PROG_REF],
                       ea_q, level};

  // Read data mux; unmapped offsets read as zero.
  assign reg_rd_val = hit_lock   ? {5'h00, lock_q} :
                      hit_key    ? key_q :
                      hit_status ? status_val :
                      csl_pkg::BYTE_ZERO;

  // Lock and key storage.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_q <= csl_pkg::LOCK_RESET;
      key_q  <= csl_pkg::KEY_NONE;
    end else begin
      lock_q <= lock_d;
      key_q  <= key_d;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= csl_pkg::BYTE_ZERO;
    end else begin
      reg_rdata_o <= reg_rd_i ? reg_rd_val : csl_pkg::BYTE_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event flags.

  // Events from the fetch and programmer paths.
  assign sticky_set[csl_pkg::ST_LEVEL_LO] = 1'b0;
  assign sticky_set[csl_pkg::ST_LEVEL_HI] = 1'b0;
  assign sticky_set[csl_pkg::ST_EA]       = 1'b0;
  assign sticky_set[csl_pkg::ST_PROG_REF] = pwr_refused;
  assign sticky_set[csl_pkg::ST_TBL_DENY] = tbl_deny;
  assign sticky_set[csl_pkg::ST_EXEC_DENY] = exec_deny;
  assign sticky_set[csl_pkg::ST_VFY_DENY] = vfy_deny;

  // Write one to clear; a new event in the same cycle keeps the flag set.
  generate
    for (genvar i = 0; i < 7; i++) begin : g_sticky
      assign sticky_d[i] = sticky_set[i] ||
                           (sticky_q[i] && !(wr_status && reg_wdata_i[i]));
    end
  endgenerate

  // Flag storage.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sticky_q <= 7'h00;
    end else begin
      sticky_q <= sticky_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External-access select handling.

  // The pin is caught at the first edge after reset release and kept in
  // the capture flop; a locked part shows that capture even when the lock
  // comes later, so a pin change can never move a locked part.
  assign ea_cap_d = cap_done_q ? ea_cap_q : external_access_select_i;
  assign ea_d     = (cap_done_q && ea_hold) ? ea_cap_q :
                    external_access_select_i;

  // Capture flag, reset capture and effective select.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cap_done_q <= 1'b0;
      ea_cap_q   <= 1'b0;
      ea_q       <= 1'b0;
    end else begin
      cap_done_q <= 1'b1;
      ea_cap_q   <= ea_cap_d;
      ea_q       <= ea_d;
    end
  end

  // The effective select leaves the block straight from its flop.
  assign ea_effective_o = ea_q;

  ////////////////////////////////////////////////////////////////////////////
  // CPU fetch path.

  // A fetch goes to internal memory when at or below the top and not forced out.
  assign tgt_int = (fetch_addr_i <= csl_pkg::INT_MEM_TOP) && !ea_q;

  // Table reads by external code may not see internal bytes once any lock bit is set.
  assign tbl_deny = fetch_req_i && code_table_read_i && fetch_from_ext_i &&
                    tgt_int && table_block;

  // Instruction fetches from external memory are refused at top level.
  assign exec_deny = fetch_req_i && !code_table_read_i && !tgt_int &&
                     ext_exec_off;

  assign fetch_deny = tbl_deny || exec_deny;
  assign fetch_byte = fetch_deny ? csl_pkg::BLOCK_DATA :
                      tgt_int    ? int_rdata_i : ext_rdata_i;

  // Fetch answer, one cycle after the request.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fetch_data_o   <= csl_pkg::BYTE_ZERO;
      fetch_valid_o  <= 1'b0;
      fetch_denied_o <= 1'b0;
    end else begin
      fetch_data_o   <= fetch_req_i ? fetch_byte : csl_pkg::BYTE_ZERO;
      fetch_valid_o  <= fetch_req_i && !fetch_deny;
      fetch_denied_o <= fetch_deny;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programmer read path: signature and verify.

  // Signature bytes answer at their fixed addresses at every level.
  assign sig_hit  = (prog_addr_i == csl_pkg::SIG_ADDR_MAKER) ||
                    (prog_addr_i == csl_pkg::SIG_ADDR_PART)  ||
                    (prog_addr_i == csl_pkg::SIG_ADDR_EXTRA);
  assign sig_byte = (prog_addr_i == csl_pkg::SIG_ADDR_MAKER) ? SIG_MAKER :
                    (prog_addr_i == csl_pkg::SIG_ADDR_PART)  ? SIG_PART  :
                    SIG_EXTRA;

  // A key other than the erased value scrambles verify data.
  assign key_on   = (key_q != csl_pkg::KEY_NONE);
  assign vfy_byte = key_on ? (prog_mem_rdata_i ^ key_q)
                           : prog_mem_rdata_i;

  // Verify is refused once the second or third lock bit is set.
  assign vfy_deny = prog_rd_i && !sig_hit && verify_off;

  assign prog_byte = sig_hit  ? sig_byte :
                     vfy_deny ? csl_pkg::BLOCK_DATA : vfy_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Programmer write path.

  // Any lock bit stops further programming of the array.
  assign pwr_ok      = prog_wr_i && !prog_lock;
  assign pwr_refused = prog_wr_i && prog_lock;

  // Programmer answers, one cycle after the strobe.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prog_rdata_o     <= csl_pkg::BYTE_ZERO;
      prog_rvalid_o    <= 1'b0;
      prog_denied_o    <= 1'b0;
    end else begin
      prog_rdata_o     <= prog_rd_i ? prog_byte : csl_pkg::BYTE_ZERO;
      prog_rvalid_o    <= prog_rd_i && !vfy_deny;
      prog_denied_o    <= vfy_deny || pwr_refused;
    end
  end

  // Write strobe to the program array with its address and data.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prog_mem_we_o    <= 1'b0;
      prog_mem_addr_o  <= csl_pkg::ADDR_ZERO;
      prog_mem_wdata_o <= csl_pkg::BYTE_ZERO;
    end else begin
      prog_mem_we_o    <= pwr_ok;
      prog_mem_addr_o  <= pwr_ok ? prog_addr_i : prog_mem_addr_o;
      prog_mem_wdata_o <= pwr_ok ? prog_wdata_i : prog_mem_wdata_o;
    end
  end

endmodule : csl_top

// *** verilog/csl_pkg.sv ***
package csl_pkg;

  // Protection levels decoded from the three one-time lock bits.
  typedef enum logic [1:0] {
    LVL_NONE,
    LVL_ONE,
    LVL_TWO,
    LVL_THREE
  } csl_level_type;

  // Lock bit patterns, ordered {third, second, first}.
  localparam logic [2:0]  LOCK_NONE      = 3'h0;
  localparam logic [2:0]  LOCK_ONE       = 3'h1;
  localparam logic [2:0]  LOCK_TWO       = 3'h3;
  localparam logic [2:0]  LOCK_THREE     = 3'h7;

  // Register port offsets.
  localparam logic [7:0]  REG_LOCK       = 8'h00;
  localparam logic [7:0]  REG_KEY        = 8'h01;
  localparam logic [7:0]  REG_STATUS     = 8'h02;

  // Status register field positions.
  localparam int          ST_LEVEL_LO    = 0;
  localparam int          ST_LEVEL_HI    = 1;
  localparam int          ST_EA          = 2;
  localparam int          ST_PROG_REF    = 3;
  localparam int          ST_TBL_DENY    = 4;
  localparam int          ST_EXEC_DENY   = 5;
  localparam int          ST_VFY_DENY    = 6;

  // Reset and fill values.
  localparam logic [2:0]  LOCK_RESET     = 3'h0;
  localparam logic [7:0]  KEY_NONE       = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [7:0]  BLOCK_DATA     = 8'hFF;
  localparam logic [15:0] ADDR_ZERO      = 16'h0000;

  // Program space layout and signature locations.
  localparam logic [15:0] INT_MEM_TOP    = 16'h3FFF;
  localparam logic [15:0] SIG_ADDR_MAKER = 16'h0030;
  localparam logic [15:0] SIG_ADDR_PART  = 16'h0031;
  localparam logic [15:0] SIG_ADDR_EXTRA = 16'h0060;

endpackage : csl_pkg

// *** verilog/csl_lock_decode.sv ***
`timescale 1ns/10ps

module csl_lock_decode (
  // Lock bits, one when programmed.
  input  wire logic [2:0]             lock_bits_i,
  // Decoded level and restrictions.
  output csl_pkg::csl_level_type      level_o,
  output logic                        table_block_o,
  output logic                        ea_hold_o,
  output logic                        prog_lock_o,
  output logic                        verify_off_o,
  output logic                        ext_exec_off_o
);

  // Map each legal pattern to its level; anything else is treated as the
  // strongest level so a stray bit can only tighten protection.
  always_comb begin
    case (lock_bits_i)
      csl_pkg::LOCK_NONE:  level_o = csl_pkg::LVL_NONE;
      csl_pkg::LOCK_ONE:   level_o = csl_pkg::LVL_ONE;
      csl_pkg::LOCK_TWO:   level_o = csl_pkg::LVL_TWO;
      csl_pkg::LOCK_THREE: level_o = csl_pkg::LVL_THREE;
      default:             level_o = csl_pkg::LVL_THREE;
    endcase
  end

  // Each level keeps every restriction of the levels below it.
  assign table_block_o  = (level_o != csl_pkg::LVL_NONE);
  assign ea_hold_o      = (level_o != csl_pkg::LVL_NONE);
  assign prog_lock_o    = (level_o != csl_pkg::LVL_NONE);
  assign verify_off_o   = (level_o == csl_pkg::LVL_TWO) ||
                          (level_o == csl_pkg::LVL_THREE);
  assign ext_exec_off_o = (level_o == csl_pkg::LVL_THREE);

endmodule : csl_lock_decode

// *** tb/csl_mem_model.sv ***
`timescale 1ns/10ps

module csl_mem_model (
  // Clock and addresses.
  input  wire logic        clk_i,
  input  wire logic [15:0] fetch_addr_i,
  input  wire logic [15:0] prog_addr_i,
  // Array write port.
  input  wire logic        prog_mem_we_i,
  input  wire logic [15:0] prog_mem_addr_i,
  input  wire logic [7:0]  prog_mem_wdata_i,
  // Read data.
  output logic      [7:0]  int_rdata_o,
  output logic      [7:0]  ext_rdata_o,
  output logic      [7:0]  prog_rdata_o
);
  logic [7:0] mem_q [256];

  // The array starts as its own low address byte and takes every write.
  initial for (int i = 0; i < 256; i++) mem_q[i] = i[7:0];
  always @(posedge clk_i) begin
    if (prog_mem_we_i) begin
      mem_q[prog_mem_addr_i[7:0]] <= prog_mem_wdata_i;
    end
  end

  // Reads are combinational, as the fetch and programmer paths expect.
  assign int_rdata_o  = mem_q[fetch_addr_i[7:0]];
  assign ext_rdata_o  = fetch_addr_i[7:0] ^ 8'hC3;
  assign prog_rdata_o = mem_q[prog_addr_i[7:0]];
endmodule : csl_mem_model

// *** tb/csl_top_asserts.sv ***
`timescale 1ns/10ps

module csl_top_asserts #(
  parameter logic [7:0] SIG_MAKER = 8'hA5
) (
  // Clock, reset and register port.
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  // Fetch path.
  input wire logic        ea_effective_o,
  input wire logic        fetch_req_i,
  input wire logic        fetch_from_ext_i,
  input wire logic        code_table_read_i,
  input wire logic [15:0] fetch_addr_i,
  input wire logic [7:0]  fetch_data_o,
  input wire logic        fetch_denied_o,
  // Programmer port.
  input wire logic        prog_rd_i,
  input wire logic        prog_wr_i,
  input wire logic [15:0] prog_addr_i,
  input wire logic [7:0]  prog_mem_rdata_i,
  input wire logic [7:0]  prog_rdata_o,
  input wire logic        prog_denied_o,
  input wire logic        prog_mem_we_o
);
  logic [2:0] lk_q;
  logic [7:0] key_q;
  logic [7:0] kx_w;
  logic       sig_w;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Shadow lock bits and key, followed from register writes.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lk_q  <= 3'h0;
      key_q <= 8'hFF;
    end else if (reg_wr_i && reg_addr_i == 8'h00) begin
      lk_q <= lk_q | reg_wdata_i[2:0];
    end else if (reg_wr_i && reg_addr_i == 8'h01 && lk_q == 3'h0) begin
      key_q <= reg_wdata_i;
    end
  end

  // Signature addresses and the effective scramble mask.
  assign sig_w = prog_addr_i inside {16'h0030, 16'h0031, 16'h0060};
  assign kx_w  = (key_q == 8'hFF) ? 8'h00 : key_q;

  // Signature byte of the maker location.
  property p_sig;
    prog_rd_i && prog_addr_i == 16'h0030 |=> prog_rdata_o == SIG_MAKER;
  endproperty
  a_sig: assert property (p_sig)
    else $error("signature byte wrong");
  // Verify refused once lock bit two or three is set.
  property p_vfy_off;
    prog_rd_i && !sig_w && lk_q[2:1] != 2'h0
    |=> prog_denied_o && prog_rdata_o == 8'hFF;
  endproperty
  a_vfy_off: assert property (p_vfy_off)
    else $error("verify not blocked");
  // Verify data is the array byte through the scramble mask.
  property p_vfy_key;
    prog_rd_i && !sig_w && lk_q[2:1] == 2'h0
    |=> prog_rdata_o == ($past(prog_mem_rdata_i) ^ $past(kx_w))
        && !prog_denied_o;
  endproperty
  a_vfy_key: assert property (p_vfy_key)
    else $error("verify data wrong");
  // Table reads from external code see no internal bytes once any lock bit is set.
  property p_tbl;
    fetch_req_i && code_table_read_i && fetch_from_ext_i && !ea_effective_o
    && fetch_addr_i <= 16'h3FFF && lk_q != 3'h0
    |=> fetch_denied_o && fetch_data_o == 8'hFF;
  endproperty
  a_tbl: assert property (p_tbl)
    else $error("table read not blocked");
  // A locked part keeps its effective select.
  property p_ea;
    lk_q != 3'h0 && $past(lk_q) != 3'h0 |=> $stable(ea_effective_o);
  endproperty
  a_ea: assert property (p_ea)
    else $error("select moved while locked");
  // Programming refused at any lock level.
  property p_wr_deny;
    prog_wr_i && lk_q != 3'h0 |=> prog_denied_o && !prog_mem_we_o;
  endproperty
  a_wr_deny: assert property (p_wr_deny)
    else $error("write not refused");
  // Programming passes on an open part.
  property p_wr_ok;
    prog_wr_i && lk_q == 3'h0 |=> prog_mem_we_o && !prog_denied_o;
  endproperty
  a_wr_ok: assert property (p_wr_ok)
    else $error("write not passed");
  // External execution refused at the top level and undefined patterns.
  property p_exec;
    fetch_req_i && !code_table_read_i && !(lk_q inside {3'h0, 3'h1, 3'h3})
    && (fetch_addr_i > 16'h3FFF || ea_effective_o) |=> fetch_denied_o;
  endproperty
  a_exec: assert property (p_exec)
    else $error("external fetch not blocked");
endmodule : csl_top_asserts

bind csl_top csl_top_asserts #(.SIG_MAKER(SIG_MAKER)) u_chk (.*);

// *** tb/code_security_lock_tb.sv ***
`timescale 1ns/10ps

module code_security_lock_tb;
  // Bench signals carry the names of the ports they drive or watch.
  logic        clk_i, reset_n_i, reg_wr_i, reg_rd_i, fetch_req_i;
  logic        external_access_select_i, fetch_from_ext_i, code_table_read_i;
  logic        prog_rd_i, prog_wr_i, ea_effective_o, fetch_valid_o;
  logic        fetch_denied_o, prog_rvalid_o, prog_denied_o, prog_mem_we_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, int_rdata_i, ext_rdata_i;
  logic [7:0]  fetch_data_o, prog_wdata_i, prog_mem_rdata_i, prog_rdata_o;
  logic [7:0]  prog_mem_wdata_o;
  logic [15:0] fetch_addr_i, prog_addr_i, prog_mem_addr_o;
  int          bad_count, checks_done;
  logic [7:0]  exp_st;
  // Lock patterns and their levels, undefined patterns last.
  logic [2:0]  pat [6] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2, 3'h4};
  logic [1:0]  lvl [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
  logic [15:0] sa [3] = '{16'h0030, 16'h0031, 16'h0060};
  logic [7:0]  sv [3] = '{8'hA5, 8'h5A, 8'h3C};

`define CHK(n, v, e) begin checks_done++; if ((v) !== (e)) begin \
  bad_count++; $display("MISMATCH %s exp %h got %h", n, e, v); end end

  csl_top dut (.*);
  csl_mem_model u_mem (
    .clk_i            (clk_i),
    .fetch_addr_i     (fetch_addr_i),
    .prog_addr_i      (prog_addr_i),
    .prog_mem_we_i    (prog_mem_we_o),
    .prog_mem_addr_i  (prog_mem_addr_o),
    .prog_mem_wdata_i (prog_mem_wdata_o),
    .int_rdata_o      (int_rdata_i),
    .ext_rdata_o      (ext_rdata_i),
    .prog_rdata_o     (prog_mem_rdata_i)
  );

  // Free-running clock of 100 ns.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // One register access; read data is looked at in the cycle after.
  task automatic rg(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i    <= wr;
    reg_rd_i    <= !wr;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
  endtask : rg

  // One programmer access.
  task automatic pg(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    prog_wr_i    <= wr;
    prog_rd_i    <= !wr;
    prog_addr_i  <= a;
    prog_wdata_i <= d;
    @(posedge clk_i);
    prog_wr_i <= 1'b0;
    prog_rd_i <= 1'b0;
    #1;
  endtask : pg

  // One CPU fetch.
  task automatic fc(input logic tbl, input logic ext, input logic [15:0] a);
    @(posedge clk_i);
    fetch_req_i       <= 1'b1;
    code_table_read_i <= tbl;
    fetch_from_ext_i  <= ext;
    fetch_addr_i      <= a;
    @(posedge clk_i);
    fetch_req_i <= 1'b0;
    #1;
  endtask : fc

  // Reset held for ten cycles.
  task automatic do_reset();
    reset_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
  endtask : do_reset

  // Counts, verdict and end of run.
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end

  // Every level in turn, then key, unmapped address and select pin.
  initial begin
    {reg_wr_i, reg_rd_i, fetch_req_i, external_access_select_i} = '0;
    {fetch_from_ext_i, code_table_read_i, prog_rd_i, prog_wr_i} = '0;
    {reg_addr_i, reg_wdata_i, prog_wdata_i, fetch_addr_i, prog_addr_i} = '0;
    bad_count = 0;
    checks_done = 0;
    for (int i = 0; i < 6; i++) begin
      do_reset();
      rg(1'b1, csl_pkg::REG_LOCK, {5'h00, pat[i]});
      rg(1'b0, csl_pkg::REG_STATUS, 8'h00);
      `CHK("level", reg_rdata_o[1:0], lvl[i])
      pg(1'b1, 16'h0010, 8'h77);
      `CHK("prog we", prog_mem_we_o, lvl[i] == 2'h0)
      `CHK("prog deny", prog_denied_o, lvl[i] != 2'h0)
      pg(1'b0, 16'h0010, 8'h00);
      `CHK("verify", prog_rdata_o, lvl[i] > 2'h1 ? 8'hFF : 8'h77)
      `CHK("rvalid", prog_rvalid_o, lvl[i] < 2'h2)
      for (int j = 0; j < 3; j++) begin
        pg(1'b0, sa[j], 8'h00);
        `CHK("signature", prog_rdata_o, sv[j])
      end
      fc(1'b1, 1'b1, 16'h0010);
      `CHK("table", fetch_data_o, lvl[i] > 2'h0 ? 8'hFF : 8'h77)
      `CHK("table deny", fetch_denied_o, lvl[i] != 2'h0)
      fc(1'b0, 1'b1, 16'h8000);
      `CHK("ext exec", fetch_data_o, lvl[i] == 2'h3 ? 8'hFF : 8'hC3)
      `CHK("ext valid", fetch_valid_o, lvl[i] != 2'h3)
      `CHK("ext deny", fetch_denied_o, lvl[i] == 2'h3)
      // Sticky flags: verify, exec, table, write refused, select, level.
      exp_st = {1'b0, lvl[i] > 2'h1, lvl[i] == 2'h3, lvl[i] != 2'h0,
                lvl[i] != 2'h0, 1'b0, lvl[i]};
      rg(1'b0, csl_pkg::REG_STATUS, 8'h00);
      `CHK("flags", reg_rdata_o, exp_st)
      rg(1'b1, csl_pkg::REG_STATUS, 8'h78);
      rg(1'b0, csl_pkg::REG_STATUS, 8'h00);
      `CHK("flags clear", reg_rdata_o, {6'h00, lvl[i]})
    end
    do_reset();
    rg(1'b1, csl_pkg::REG_KEY, 8'h0F);
    pg(1'b0, 16'h0010, 8'h00);
    `CHK("scrambled", prog_rdata_o, 8'h78)
    rg(1'b0, 8'h05, 8'h00);
    `CHK("unmapped", reg_rdata_o, 8'h00)
    // Pin goes high and stays high; the lock must restore the reset capture.
    @(posedge clk_i);
    external_access_select_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("ea follows", ea_effective_o, 1'b1)
    rg(1'b1, csl_pkg::REG_LOCK, {5'h00, csl_pkg::LOCK_ONE});
    rg(1'b1, csl_pkg::REG_KEY, 8'h00);
    pg(1'b0, 16'h0010, 8'h00);
    `CHK("key kept", prog_rdata_o, 8'h78)
    `CHK("ea held", ea_effective_o, 1'b0)
    fc(1'b1, 1'b0, 16'h0010);
    `CHK("table int", fetch_data_o, 8'h77)
    tally_and_finish();
  end
endmodule : code_security_lock_tb
